// File: rtl/iocp_pkg.sv
package iocp_pkg;
  // datapath and sizes
  localparam int DATA_W      = 16;
  localparam int NUM_REGS    = 8;
  localparam int NUM_REQ     = 8;
  localparam int NUM_SEM     = 8;
  localparam int AXI_ADDR_W  = 8;
  localparam int FFO_POS_W   = 4;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SWREQ  = 8'h04;
  localparam logic [7:0] ADDR_PEND   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_VBASE  = 8'h10;
  localparam logic [7:0] ADDR_IRQF   = 8'h14;
  localparam logic [7:0] ADDR_SEM    = 8'h18;

  localparam int CTRL_EN_BIT       = 0;
  localparam int STAT_BUSY_BIT     = 0;
  localparam int STAT_FLAGS_LSB    = 4;
  localparam int STAT_CH_LSB       = 8;
  localparam logic [15:0] VBASE_RST = 16'h0000;
  localparam int VEC_SHIFT          = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // condition flag positions
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;

  // opcodes, bits 15:11
  localparam logic [4:0] OP_CTL  = 5'h00;
  localparam logic [4:0] OP_DYAD = 5'h01;
  localparam logic [4:0] OP_SEM  = 5'h02;
  localparam logic [4:0] OP_BR   = 5'h04;
  localparam logic [4:0] OP_LD   = 5'h08;
  localparam logic [4:0] OP_ST   = 5'h09;
  localparam logic [4:0] OP_TRI  = 5'h0A;
  localparam logic [4:0] OP_LDL  = 5'h12;
  localparam logic [4:0] OP_ADDI = 5'h18;

  // dyadic suffixes, bits 4:0
  localparam logic [4:0] SFX_MOV = 5'h00;
  localparam logic [4:0] SFX_AND = 5'h01;
  localparam logic [4:0] SFX_OR  = 5'h02;
  localparam logic [4:0] SFX_XOR = 5'h03;
  localparam logic [4:0] SFX_FFO = 5'h10;

  localparam logic [1:0] TRI_ADD = 2'h0;
  localparam logic [1:0] TRI_SUB = 2'h1;

  localparam logic [2:0] BR_ALWAYS = 3'h0;
  localparam logic [2:0] BR_EQ     = 3'h1;
  localparam logic [2:0] BR_NE     = 3'h2;
  localparam logic [2:0] BR_CS     = 3'h3;
  localparam logic [2:0] BR_CC     = 3'h4;
  localparam logic [2:0] BR_MI     = 3'h5;

  // shared bus pacing
  localparam int RAM_REGION_BIT      = 15;
  localparam int SYS_CLK_PERIOD_NS   = 10;
  localparam int HOST_BUS_PERIOD_NS  = 20;
  localparam int HOST_DIV            = HOST_BUS_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam logic [1:0] RAM_PER_HOST_CYCLE = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_MEM} core_state_t;
endpackage

// File: rtl/ffo_unit.sv
`timescale 1ns/1ps
module ffo_unit #(
  parameter int W  = 16,
  parameter int PW = 4
) (
  // operand
  input  wire logic [W-1:0]  value,
  // result
  output logic      [PW-1:0] position,
  output logic               none
);
  // later hits overwrite, so the highest set bit wins
  always_comb begin
    position = '0;
    for (int i = 0; i < W; i++) begin
      if (value[i]) begin
        position = PW'(i);
      end
    end
  end

  assign none = (value == '0);
endmodule

// File: rtl/sem_unit.sv
`timescale 1ns/1ps
module sem_unit #(
  parameter int N  = 8,
  parameter int IW = 3
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // host side: low half values, high half write mask
  input  wire logic          host_we,
  input  wire logic [2*N-1:0] host_wdata,
  // core side
  input  wire logic          core_lock,
  input  wire logic          core_release,
  input  wire logic [IW-1:0] core_idx,
  output logic               core_grant,
  // ownership
  output logic      [N-1:0]  host_owns,
  output logic      [N-1:0]  core_owns
);
  logic [N-1:0] host_try;
  logic [N-1:0] host_rel;

  always_comb begin
    host_try = host_we ? (host_wdata[2*N-1:N] & host_wdata[N-1:0]) : '0;
    host_rel = host_we ? (host_wdata[2*N-1:N] & ~host_wdata[N-1:0]) : '0;
  end

  // host wins a same-cycle race so the host is never held up
  assign core_grant = core_owns[core_idx] | (~host_owns[core_idx] & ~host_try[core_idx]);

  always_ff @(posedge clk) begin
    if (srst) begin
      host_owns <= '0;
      core_owns <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (host_try[i] && !core_owns[i]) begin
          host_owns[i] <= 1'b1;
        end else if (host_rel[i]) begin
          host_owns[i] <= 1'b0;
        end
        if (core_lock && core_idx == IW'(i) && core_grant) begin
          core_owns[i] <= 1'b1;
        end else if (core_release && core_idx == IW'(i)) begin
          core_owns[i] <= 1'b0;
        end
      end
    end
  end
endmodule

// File: rtl/io_coprocessor.sv
// How it works
// - The core sits idle and fetches nothing until a service request starts it.
// - A request runs the code sequence at its vector and the closing instruction may flag the host.
// - A running sequence is never preempted; pending requests wait until the core is idle again.
// - Hardware semaphores let core and host claim shared locations without conflict.
// - The datapath is 16 bits wide with moves, bit operations and add/subtract.
// - On a shared-resource conflict the core waits for the bus acknowledge while the host runs on.
// - The core issues at most two RAM accesses per host bus cycle.
// - The core issues at most one peripheral or flash access per host bus cycle.
// - Find-first-one scans from MSB down and writes the bit position with upper bits cleared.
// - A zero source makes find-first-one clear the destination and set carry, else carry clears.
// - Find-first-one clears negative and overflow and sets zero only for a zero result.
`timescale 1ns/1ps
module io_coprocessor
  import iocp_pkg::*;
#(
  parameter int NREQ = NUM_REQ
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  // axi4-lite write
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // service requests and host notification
  input  wire logic [NREQ-1:0]       service_req,
  output logic [NREQ-1:0]            host_irq,
  output logic                       core_busy,
  // shared memory bus
  output logic                       mem_req,
  output logic                       mem_we,
  output logic [DATA_W-1:0]          mem_addr,
  output logic [DATA_W-1:0]          mem_wdata,
  input  wire logic [DATA_W-1:0]     mem_rdata,
  input  wire logic                  mem_ack
);
  localparam int CHW = $clog2(NREQ);
  localparam int SIW = $clog2(NUM_SEM);

  logic [AXI_ADDR_W-1:0] awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  aw_full_reg, w_full_reg;
  logic                  ctrl_en_reg;
  logic [DATA_W-1:0]     vbase_reg;
  logic [NREQ-1:0]       pend_reg;
  core_state_t           state_reg;
  logic [DATA_W-1:0]     regs_reg [NUM_REGS];
  logic [DATA_W-1:0]     pc_reg, ir_reg, ea_reg;
  logic [3:0]            flags_reg;
  logic [CHW-1:0]        chan_reg;
  logic                  is_load_reg;
  logic [$clog2(HOST_DIV+1)-1:0] div_reg;
  logic [1:0]            ram_cnt_reg;
  logic                  per_cnt_reg;

  function automatic logic [7:0] word_addr(input logic [AXI_ADDR_W-1:0] a);
    return {a[7:2], 2'b00};
  endfunction

  function automatic logic [CHW-1:0] first_pending(input logic [NREQ-1:0] p);
    logic [CHW-1:0] r;
    r = '0;
    for (int i = NREQ - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = CHW'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] rf(input logic [2:0] idx);
    return (idx == 3'h0) ? '0 : regs_reg[idx];
  endfunction

  // returns {n,z,v,c,result}
  function automatic logic [DATA_W+3:0] addsub(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                               input logic sub);
    logic [DATA_W-1:0] bb;
    logic [DATA_W:0]   s;
    bb = sub ? ~b : b;
    s  = {1'b0, a} + {1'b0, bb} + {{DATA_W{1'b0}}, sub};
    return {s[DATA_W-1], s[DATA_W-1:0] == '0, (a[DATA_W-1] == bb[DATA_W-1]) && (s[DATA_W-1] != a[DATA_W-1]),
            s[DATA_W] ^ sub, s[DATA_W-1:0]};
  endfunction

  // ---------------- register bus ----------------
  logic do_write;
  logic [7:0] wa;
  logic wr_ctrl, wr_swreq, wr_vbase, wr_irqf, wr_sem, wr_hit;
  logic [15:0] wlo;

  always_comb begin
    do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wa       = word_addr(awaddr_reg);
    wlo      = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00, wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};
    wr_ctrl  = do_write && wa == ADDR_CTRL && wstrb_reg[0];
    wr_swreq = do_write && wa == ADDR_SWREQ;
    wr_vbase = do_write && wa == ADDR_VBASE && (wstrb_reg[1:0] != 2'h0);
    wr_irqf  = do_write && wa == ADDR_IRQF;
    wr_sem   = do_write && wa == ADDR_SEM;
    wr_hit   = wa == ADDR_CTRL || wa == ADDR_SWREQ || wa == ADDR_PEND || wa == ADDR_STATUS ||
               wa == ADDR_VBASE || wa == ADDR_IRQF || wa == ADDR_SEM;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
    end else begin
      if (do_write) begin
        aw_full_reg <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (do_write) begin
        w_full_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      s_axi_awready <= do_write || !(aw_full_reg || (s_axi_awvalid && s_axi_awready));
      s_axi_wready  <= do_write || !(w_full_reg || (s_axi_wvalid && s_axi_wready));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [NUM_SEM-1:0] sem_host_owns, sem_core_owns;
  logic [31:0]        rd_mux;
  logic               rd_hit;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (word_addr(s_axi_araddr))
      ADDR_CTRL:   rd_mux[CTRL_EN_BIT] = ctrl_en_reg;
      ADDR_SWREQ:  rd_mux = 32'h0000_0000;
      ADDR_PEND:   rd_mux[NREQ-1:0] = pend_reg;
      ADDR_STATUS: begin
        rd_mux[STAT_BUSY_BIT] = state_reg != ST_IDLE;
        rd_mux[STAT_FLAGS_LSB +: 4] = flags_reg;
        rd_mux[STAT_CH_LSB +: CHW] = chan_reg;
      end
      ADDR_VBASE:  rd_mux[DATA_W-1:0] = vbase_reg;
      ADDR_IRQF:   rd_mux[NREQ-1:0] = host_irq;
      ADDR_SEM:    rd_mux[NUM_SEM-1:0] = sem_host_owns;
      default:     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_en_reg <= 1'b0;
      vbase_reg   <= VBASE_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_reg <= wdata_reg[CTRL_EN_BIT];
      end
      if (wr_vbase) begin
        vbase_reg <= wlo;
      end
    end
  end

  // ---------------- decode and execute ----------------
  logic [4:0] op;
  logic [2:0] f_rd, f_src, f_rt;
  logic [DATA_W-1:0] va, vb, vd, wb_val, br_tgt;
  logic [DATA_W+3:0] as_res;
  logic [FFO_POS_W-1:0] ffo_pos;
  logic ffo_none, wb_en, br_take, sem_grant, start, seq_done;
  logic [3:0] flags_nx;

  always_comb begin
    op   = ir_reg[15:11];
    f_rd = ir_reg[10:8];
    f_src = ir_reg[7:5];
    f_rt = ir_reg[4:2];
    va   = rf(f_src);
    vb   = rf(f_rt);
    vd   = rf(f_rd);
    as_res = addsub(op == OP_ADDI ? vd : va, op == OP_ADDI ? {{8{ir_reg[7]}}, ir_reg[7:0]} : vb,
                    op == OP_TRI && ir_reg[1:0] == TRI_SUB);
    wb_en    = 1'b0;
    wb_val   = '0;
    flags_nx = flags_reg;
    case (op)
      OP_DYAD: begin
        wb_en = 1'b1;
        case (ir_reg[4:0])
          SFX_FFO: begin
            wb_val = ffo_none ? '0 : {{(DATA_W-FFO_POS_W){1'b0}}, ffo_pos};
            flags_nx = {1'b0, wb_val == '0, 1'b0, ffo_none};
          end
          SFX_AND: wb_val = vd & va;
          SFX_OR:  wb_val = vd | va;
          SFX_XOR: wb_val = vd ^ va;
          default: wb_val = va;
        endcase
        if (ir_reg[4:0] != SFX_FFO) begin
          flags_nx = {wb_val[DATA_W-1], wb_val == '0, 1'b0, flags_reg[FLAG_C]};
        end
      end
      OP_TRI, OP_ADDI: begin
        wb_en    = 1'b1;
        wb_val   = as_res[DATA_W-1:0];
        flags_nx = as_res[DATA_W+3:DATA_W];
      end
      OP_LDL: begin
        wb_en  = 1'b1;
        wb_val = {8'h00, ir_reg[7:0]};
      end
      OP_SEM: flags_nx[FLAG_C] = ir_reg[10] ? 1'b0 : sem_grant;
      default: ;
    endcase
    case (ir_reg[10:8])
      BR_ALWAYS: br_take = 1'b1;
      BR_EQ:     br_take = flags_reg[FLAG_Z];
      BR_NE:     br_take = !flags_reg[FLAG_Z];
      BR_CS:     br_take = flags_reg[FLAG_C];
      BR_CC:     br_take = !flags_reg[FLAG_C];
      BR_MI:     br_take = flags_reg[FLAG_N];
      default:   br_take = 1'b0;
    endcase
    br_tgt   = pc_reg + {{8{ir_reg[7]}}, ir_reg[7:0]};
    seq_done = state_reg == ST_EXEC && op == OP_CTL;
    start    = state_reg == ST_IDLE && ctrl_en_reg && (pend_reg != '0);
  end

  ffo_unit #(.W(DATA_W), .PW(FFO_POS_W)) u_ffo (
    .value    (va),
    .position (ffo_pos),
    .none     (ffo_none)
  );

  sem_unit #(.N(NUM_SEM), .IW(SIW)) u_sem (
    .clk          (sys_clk),
    .srst         (srst),
    .host_we      (wr_sem),
    .host_wdata   (wlo),
    .core_lock    (state_reg == ST_EXEC && op == OP_SEM && !ir_reg[10]),
    .core_release (state_reg == ST_EXEC && op == OP_SEM && ir_reg[10]),
    .core_idx     (ir_reg[9:7]),
    .core_grant   (sem_grant),
    .host_owns    (sem_host_owns),
    .core_owns    (sem_core_owns)
  );

  // requests: a new arrival beats the clear of the same bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_reg <= '0;
      host_irq <= '0;
    end else begin
      pend_reg <= (pend_reg & ~(start ? (NREQ'(1) << first_pending(pend_reg)) : '0))
                  | service_req | (wr_swreq ? wlo[NREQ-1:0] : '0);
      host_irq <= (host_irq & ~(wr_irqf ? wlo[NREQ-1:0] : '0))
                  | ((seq_done && ir_reg[0]) ? (NREQ'(1) << chan_reg) : '0);
    end
  end

  // ---------------- shared bus pacing ----------------
  logic host_cyc, launch, slot_ok;
  logic [DATA_W-1:0] launch_addr;

  always_comb begin
    host_cyc    = div_reg == '0;
    launch_addr = state_reg == ST_MEM ? ea_reg : pc_reg;
    slot_ok     = launch_addr[RAM_REGION_BIT] ? (ram_cnt_reg < RAM_PER_HOST_CYCLE) : !per_cnt_reg;
    launch      = (state_reg == ST_FETCH || state_reg == ST_MEM) && !mem_req && slot_ok;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_reg     <= '0;
      ram_cnt_reg <= '0;
      per_cnt_reg <= 1'b0;
    end else begin
      div_reg <= (div_reg == ($bits(div_reg))'(HOST_DIV - 1)) ? '0 : div_reg + 1'b1;
      if (host_cyc) begin
        ram_cnt_reg <= (launch && launch_addr[RAM_REGION_BIT]) ? 2'h1 : 2'h0;
        per_cnt_reg <= launch && !launch_addr[RAM_REGION_BIT];
      end else if (launch) begin
        if (launch_addr[RAM_REGION_BIT]) begin
          ram_cnt_reg <= ram_cnt_reg + 2'h1;
        end else begin
          per_cnt_reg <= 1'b1;
        end
      end
    end
  end

  // ---------------- sequencer ----------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg   <= ST_IDLE;
      pc_reg      <= '0;
      ir_reg      <= '0;
      ea_reg      <= '0;
      flags_reg   <= '0;
      chan_reg    <= '0;
      is_load_reg <= 1'b0;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= '0;
      mem_wdata   <= '0;
      core_busy   <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= '0;
      end
    end else begin
      core_busy <= state_reg != ST_IDLE || start;
      if (launch) begin
        mem_req  <= 1'b1;
        mem_addr <= launch_addr;
        mem_we   <= state_reg == ST_MEM && !is_load_reg;
      end else if (mem_req && mem_ack) begin
        mem_req <= 1'b0;
        mem_we  <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            chan_reg  <= first_pending(pend_reg);
            pc_reg    <= vbase_reg + (DATA_W'(first_pending(pend_reg)) << VEC_SHIFT);
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mem_req && mem_ack) begin
            ir_reg    <= mem_rdata;
            pc_reg    <= pc_reg + 16'h0001;
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          flags_reg <= flags_nx;
          if (wb_en && f_rd != 3'h0) begin
            regs_reg[f_rd] <= wb_val;
          end
          state_reg <= ST_FETCH;
          case (op)
            OP_CTL: state_reg <= ST_IDLE;
            OP_BR: begin
              if (br_take) begin
                pc_reg <= br_tgt;
              end
            end
            OP_LD, OP_ST: begin
              ea_reg      <= va + {11'h000, ir_reg[4:0]};
              is_load_reg <= op == OP_LD;
              mem_wdata   <= vd;
              state_reg   <= ST_MEM;
            end
            default: ;
          endcase
        end
        ST_MEM: begin
          if (mem_req && mem_ack) begin
            if (is_load_reg && f_rd != 3'h0) begin
              regs_reg[f_rd] <= mem_rdata;
            end
            state_reg <= ST_FETCH;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// File: dv/iocp_chk.sv
`timescale 1ns/1ps
module iocp_chk
  import iocp_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // core status and memory bus
  input wire logic        core_busy,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
                               $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before acknowledge");
  a_mem_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after acknowledge");
  a_periph_rate: assert property ($rose(mem_req) && !mem_addr[15] |=> !$rose(mem_req))
    else $error("peripheral access rate exceeded");
  a_fetch_busy: assert property ($rose(mem_req) |-> ##[0:2] core_busy)
    else $error("memory access while core idle");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                                |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");

  c_ram_fetch: cover property ($rose(mem_req) && mem_addr[15]);
  c_periph_st: cover property (mem_req && mem_we && !mem_addr[15]);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind io_coprocessor iocp_chk u_chk (.*);

// File: dv/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // memory bus from the core
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  output logic             ack,
  // extra wait cycles before each acknowledge
  input  wire logic [3:0]  stall
);
  logic [15:0] mem [logic [15:0]];
  logic [15:0] wlog [$];
  logic [3:0]  wait_reg;
  int          n_acc;

  // data churns outside the ack cycle so a stale word never passes for a read
  always @(posedge clk) begin
    if (srst) begin
      ack      <= 1'b0;
      wait_reg <= 4'h0;
      rdata    <= 16'hA5A5;
      n_acc    <= 0;
    end else if (req && !ack && wait_reg >= stall) begin
      ack      <= 1'b1;
      wait_reg <= 4'h0;
      n_acc    <= n_acc + 1;
      rdata    <= (!we && mem.exists(addr)) ? mem[addr] : ~rdata;
      if (we) begin
        mem[addr] = wdata;
        wlog.push_back(addr);
      end
    end else begin
      ack      <= 1'b0;
      rdata    <= ~rdata;
      wait_reg <= (req && !ack) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module tb
  import iocp_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, service_req = 8'h00, host_irq;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF, stall = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        core_busy, mem_req, mem_we, mem_ack;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [15:0] p0 [5] = '{16'h9200, 16'h1000, 16'h0B50, 16'h4B00, 16'h0001};
  logic [15:0] p1 [5] = '{16'h9200, 16'hC2FF, 16'h0B50, 16'h4B01, 16'h0001};
  int          errors = 0, total_checks = 0;

  always #5 sys_clk = ~sys_clk;

  io_coprocessor DUT (.*);
  mem_model u_mem (.clk(sys_clk), .srst(srst), .req(mem_req), .we(mem_we), .addr(mem_addr),
                   .wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack), .stall(stall));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // ready comes late on purpose so the slave has to hold its answer
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    rd   = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_reg(a);
    `CHK(nm, e, rd & m)
  endtask

  // bounded wait for the done flags of the given channels
  task automatic wait_irq(input logic [7:0] m);
    int n;
    n = 0;
    while ((host_irq & m) !== m && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("host_irq", m, host_irq & m)
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    wrap_up();
  end

  initial begin
    for (int i = 0; i < 5; i++) begin
      u_mem.mem[16'h8000 + 16'(i)] = p0[i];
      u_mem.mem[16'h8040 + 16'(i)] = p1[i];
    end
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rchk("ctrl", ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    rchk("vbase", ADDR_VBASE, 32'hFFFFFFFF, 32'h0);
    rchk("pend", ADDR_PEND, 32'hFFFFFFFF, 32'h0);
    rd_reg(8'h40);
    `CHK("rresp", RESP_SLVERR, resp)
    wr(8'h40, 32'h1);
    `CHK("bresp", RESP_SLVERR, resp)
    wr(ADDR_SEM, 32'h0101);
    rchk("sem lock", ADDR_SEM, 32'hFF, 32'h1);
    wr(ADDR_SEM, 32'h0100);
    rchk("sem free", ADDR_SEM, 32'hFF, 32'h0);
    // a request posted while disabled must stay pending with no fetch
    wr(ADDR_VBASE, 32'h8000);
    service_req <= 8'h01;
    @(posedge sys_clk);
    service_req <= 8'h00;
    repeat (20) @(posedge sys_clk);
    `CHK("idle accesses", 0, u_mem.n_acc)
    rchk("pend one", ADDR_PEND, 32'hFF, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    wait_irq(8'h01);
    rchk("zero src flags", ADDR_STATUS, 32'hF0, 32'h50);
    `CHK("zero src result", 16'h0000, u_mem.mem[16'h0000])
    `CHK("busy idle", 1'b0, core_busy)
    // the sequence locked semaphore 0, so the host must be refused
    wr(ADDR_SEM, 32'h0101);
    rchk("sem held by core", ADDR_SEM, 32'hFF, 32'h0);
    wr(ADDR_IRQF, 32'h1);
    @(posedge sys_clk);
    `CHK("irq cleared", 8'h00, host_irq)
    // two channels queued at once, served in order under a stalled bus
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_SWREQ, 32'h3);
    rchk("pend two", ADDR_PEND, 32'hFF, 32'h3);
    stall <= 4'h3;
    wr(ADDR_CTRL, 32'h1);
    wait_irq(8'h03);
    `CHK("first store", 16'h0000, u_mem.wlog[1])
    `CHK("second store", 16'h0001, u_mem.wlog[2])
    `CHK("msb position", 16'h000F, u_mem.mem[16'h0001])
    rchk("msb flags", ADDR_STATUS, 32'hF0, 32'h00);
    wrap_up();
  end
endmodule
